/* uart_interrupt_enable_status.sv */
// interrupt enable, prioritised status and clearing logic of a fifo uart
// assumes bus address and write data are stable while a strobe is low
`default_nettype none

//
// Function
// - fifo receive interrupt follows trigger level
// - data ready set on receive, cleared empty
// - line status bits carry documented meanings
// - enable bit 0 raises receive ready
// - transmit ready, immediate if already empty
// - overrun immediate, head errors at head
// - early mode flags errors on enqueue
// - modem status interrupt from status bits
// - upper enable bits need enhanced mode
// - rts/cts rising edges under auto flow
// - status read shows highest pending only
// - time-out after four chars twelve bits
// - tx ready cleared by status read, write
// - line/modem status reads clear their interrupts
// - receive ready by level; data read clears time-out
// - xon/xoff cleared by read, special by read or next char
// - wake-up interrupt, code of no interrupt
// - six-bit priority codes per source
// - bit 0 low while pending except wake-up, source bits
// - bit 4 flags character match, enhanced only
// - bit 5 flags rts/cts rise, enhanced only
// - bits 7:6 mirror fifo enable
module uart_interrupt_enable_status
    import uart_irq_pkg::*;
#(
    parameter int TMR_W = 8
)
(
    input wire logic clock,
    input wire logic arst_n,
    input wire logic bus_cs_n,
    input wire logic bus_rd_n,
    input wire logic bus_wr_n,
    input wire logic [2:0] bus_addr,
    input wire logic [7:0] bus_data_in,
    output logic [7:0] bus_data_out,
    output logic bus_data_oe,
    input wire logic cts_n,
    input wire uart_irq_pkg::uart_evt_s evt,
    input wire uart_irq_pkg::uart_cfg_s cfg,
    output logic irq,
    output logic sleep_en,
    output logic [7:0] line_status
);
    import uart_irq_pkg::*;

    localparam int PIN_CTS = 2;
    localparam int PIN_RD = 1;
    localparam int PIN_WR = 0;

    // time-out limit in bit times for the current character length
    function automatic logic [TMR_W-1:0] timeout_limit(input logic [3:0] bits);
        timeout_limit = TMR_W'(TIMEOUT_CHARS * int'(bits) + TIMEOUT_BITS);
    endfunction

    logic [2:0] pin_raw, s1_q, s2_q, s3_q, stable_q, rise;
    logic [7:0] ier_q, ier_eff, isr_q, isr_d, lsr_q, rdata_q;
    logic oe_q, irq_q, sleep_q;
    logic ours, rhr_rd, thr_wr, ier_wr, isr_rd, lsr_rd, msr_rd;
    logic ls_pend_q, ls_set;
    logic [2:0] head_prev_q;
    logic to_pend_q, to_set;
    logic [TMR_W-1:0] tmr_q;
    logic rx_lvl, tx_cond, tx_cond_prev_q, tx_pend_q, tx_set, ms_lvl;
    logic xch_pend_q, spc_pend_q, xch_set, spc_set;
    logic flow_pend_q, flow_set, rts_prev_q;
    logic wake_pend_q, wake_set, any_pend;

    // pins cross into the clock through three flops
    assign pin_raw = {cts_n, ~bus_cs_n & ~bus_rd_n, ~bus_cs_n & ~bus_wr_n};

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            s1_q <= 3'h0;
            s2_q <= 3'h0;
            s3_q <= 3'h0;
            stable_q <= 3'h0;
        end
        else
        begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            stable_q <= (s2_q & s3_q) | (stable_q & (s2_q | s3_q)); // hold until both agree
        end
    end

    // a rise counts once the late stages agree high
    assign rise = s2_q & s3_q & ~stable_q;

    // decode; divisor latch select hides the low addresses
    assign ours = !(cfg.dlab && (bus_addr == ADDR_DATA || bus_addr == ADDR_IER));
    assign rhr_rd = rise[PIN_RD] && ours && bus_addr == ADDR_DATA;
    assign thr_wr = rise[PIN_WR] && ours && bus_addr == ADDR_DATA;
    assign ier_wr = rise[PIN_WR] && ours && bus_addr == ADDR_IER;
    assign isr_rd = rise[PIN_RD] && bus_addr == ADDR_ISR;
    assign lsr_rd = rise[PIN_RD] && bus_addr == ADDR_LSR;
    assign msr_rd = rise[PIN_RD] && bus_addr == ADDR_MSR;

    // enable register
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            ier_q <= IER_RESET;
        else if (ier_wr)
            ier_q <= bus_data_in;
    end

    // upper enables are inert outside enhanced mode
    assign ier_eff = cfg.enh ? ier_q : (ier_q & IER_BASE_MASK);

    // line status flags; set wins over clear
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            lsr_q <= LSR_RESET;
        else
        begin
            lsr_q[0] <= evt.char_rx | (lsr_q[0] & ~evt.rx_empty);
            lsr_q[1] <= evt.overrun | (lsr_q[1] & ~lsr_rd);
            lsr_q[4:2] <= evt.head_err;
            lsr_q[5] <= evt.thr_empty;
            lsr_q[6] <= evt.tx_all_empty;
            lsr_q[7] <= evt.fifo_err;
        end
    end

    // line status interrupt: overrun at once, errors at head or on entry
    assign ls_set = ier_eff[IER_LS] && (evt.overrun ||
        (cfg.early_err ? evt.enq_err : |(evt.head_err & ~head_prev_q)));

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ls_pend_q <= 1'b0;
            head_prev_q <= 3'h0;
        end
        else
        begin
            head_prev_q <= evt.head_err;
            ls_pend_q <= ls_set | (ls_pend_q & ~lsr_rd);
        end
    end

    // time-out counts bit ticks while data waits unread
    assign to_set = evt.fifo_en && ier_eff[IER_RX] && !to_pend_q && !evt.rx_empty &&
        tmr_q >= timeout_limit(cfg.char_bits);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            tmr_q <= '0;
        else if (evt.char_rx || rhr_rd || evt.rx_empty)
            tmr_q <= '0;
        else if (evt.bit_tick && tmr_q < timeout_limit(cfg.char_bits))
            tmr_q <= tmr_q + 1'b1;
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            to_pend_q <= 1'b0;
        else
            to_pend_q <= to_set | (to_pend_q & ~rhr_rd);
    end

    // receive ready is a pure level: it drops as reads drain the fifo
    assign rx_lvl = ier_eff[IER_RX] && (evt.fifo_en ? evt.rx_at_trigger : evt.rhr_full);

    // transmit ready on the edge of its condition, or on enabling while true
    assign tx_cond = evt.fifo_en ? (evt.tx_below_trig | evt.thr_empty) : evt.thr_empty;
    // the enable flop is still old on the write edge, so the write data decides there
    assign tx_set = tx_cond && ((ier_eff[IER_TX] && !tx_cond_prev_q) ||
        (ier_wr && bus_data_in[IER_TX] && !ier_q[IER_TX]));

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            tx_cond_prev_q <= 1'b0;
            tx_pend_q <= 1'b0;
        end
        else
        begin
            tx_cond_prev_q <= tx_cond;
            // a holding write, a dropped enable, or a status read that reported it as the source clears it
            tx_pend_q <= tx_set | (tx_pend_q & ier_eff[IER_TX] & ~thr_wr &
                ~(isr_rd && isr_q[5:0] == CODE_TX));
        end
    end

    assign ms_lvl = ier_eff[IER_MS] && evt.msr_any;

    // character match interrupts
    assign xch_set = ier_eff[IER_XOFF] && (evt.xon || evt.xoff);
    assign spc_set = ier_eff[IER_XOFF] && evt.special;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            xch_pend_q <= 1'b0;
            spc_pend_q <= 1'b0;
        end
        else
        begin
            xch_pend_q <= xch_set | (xch_pend_q & ~(isr_rd && isr_q[5:0] == CODE_XCH));
            spc_pend_q <= spc_set | (spc_pend_q & ~evt.char_rx &
                ~(isr_rd && isr_q[5:0] == CODE_XCH));
        end
    end

    // flow control edges; rts is our own output so needs no synchroniser
    assign flow_set = (ier_eff[IER_RTS] && cfg.auto_rts && evt.rts_out && !rts_prev_q) ||
        (ier_eff[IER_CTS] && cfg.auto_cts && rise[PIN_CTS]);

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rts_prev_q <= 1'b0;
            flow_pend_q <= 1'b0;
        end
        else
        begin
            rts_prev_q <= evt.rts_out;
            flow_pend_q <= flow_set | (flow_pend_q & ~msr_rd);
        end
    end

    // wake-up shares the code of no interrupt, so only the pin shows it
    assign wake_set = cfg.enh && cfg.wake_en && evt.wake;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            wake_pend_q <= 1'b0;
        else
            wake_pend_q <= wake_set | (wake_pend_q & ~isr_rd);
    end

    assign any_pend = ls_pend_q | to_pend_q | rx_lvl | tx_pend_q | ms_lvl |
        xch_pend_q | spc_pend_q | flow_pend_q | wake_pend_q;

    // priority encoder; lower sources wait queued behind the reported one
    always_comb
    begin
        isr_d = {evt.fifo_en, evt.fifo_en, CODE_NONE};
        if (ls_pend_q)
            isr_d[5:0] = CODE_LS;
        else if (to_pend_q)
            isr_d[5:0] = CODE_TO;
        else if (rx_lvl)
            isr_d[5:0] = CODE_RX;
        else if (tx_pend_q)
            isr_d[5:0] = CODE_TX;
        else if (ms_lvl)
            isr_d[5:0] = CODE_MS;
        else if (cfg.enh && (xch_pend_q || spc_pend_q))
            isr_d[5:0] = CODE_XCH;
        else if (cfg.enh && flow_pend_q)
            isr_d[5:0] = CODE_FLOW;
    end

    // status, interrupt pin and sleep enable from one registered view
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            isr_q <= ISR_RESET;
            irq_q <= 1'b0;
            sleep_q <= 1'b0;
        end
        else
        begin
            isr_q <= isr_d;
            irq_q <= any_pend;
            sleep_q <= ier_eff[IER_SLEEP];
        end
    end

    // read data captured at the start of a read, driven while it lasts
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= 8'h00;
            oe_q <= 1'b0;
        end
        else
        begin
            oe_q <= stable_q[PIN_RD] | rise[PIN_RD];
            if (rise[PIN_RD])
            begin
                unique case (bus_addr)
                    ADDR_IER: rdata_q <= ours ? ier_q : 8'h00;
                    ADDR_ISR: rdata_q <= isr_q;
                    ADDR_LSR: rdata_q <= lsr_q;
                    default: rdata_q <= 8'h00;
                endcase
            end
        end
    end

    assign bus_data_out = rdata_q;
    assign bus_data_oe = oe_q;
    assign irq = irq_q;
    assign sleep_en = sleep_q;
    assign line_status = lsr_q;

    // checks
    sequence cts_rise_s;
        ier_eff[IER_CTS] && cfg.auto_cts && rise[PIN_CTS];
    endsequence

    sequence lsr_read_s;
        lsr_rd && !ls_set;
    endsequence

    pend_pin_a: assert property (@(posedge clock) disable iff (!arst_n)
        !isr_q[0] |-> irq_q) else $error("status pending but pin idle");
    fifo_bits_a: assert property (@(posedge clock) disable iff (!arst_n)
        ##1 isr_q[7:6] == {2{$past(evt.fifo_en)}}) else $error("fifo bits wrong");
    lsr_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        lsr_read_s |=> !ls_pend_q) else $error("line status not cleared");
    ovr_raise_a: assert property (@(posedge clock) disable iff (!arst_n)
        ier_eff[IER_LS] && evt.overrun |=> ##1 isr_q[5:0] == CODE_LS) else $error("overrun not first");
    timeout_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        to_set && !rhr_rd |=> to_pend_q ##1 (to_pend_q || $past(rhr_rd))) else $error("time-out lost");
    rx_level_a: assert property (@(posedge clock) disable iff (!arst_n)
        evt.fifo_en && ier_eff[IER_RX] && evt.rx_at_trigger |=> irq_q) else $error("rx level no irq");
    tx_enable_a: assert property (@(posedge clock) disable iff (!arst_n)
        ier_wr && bus_data_in[IER_TX] && !ier_q[IER_TX] && evt.thr_empty && !evt.fifo_en
        |=> tx_pend_q) else $error("no immediate tx");
    thr_clear_a: assert property (@(posedge clock) disable iff (!arst_n)
        thr_wr && !tx_set |=> !tx_pend_q) else $error("tx ready not cleared");
    cts_flow_a: assert property (@(posedge clock) disable iff (!arst_n)
        cts_rise_s |=> flow_pend_q) else $error("cts rise missed");
    data_ready_a: assert property (@(posedge clock) disable iff (!arst_n)
        evt.char_rx |=> lsr_q[0]) else $error("data ready not set");

endmodule

`default_nettype wire

/* uart_irq_pkg.sv */
// constants and carriers for the uart interrupt enable and status block
// assumes the datapath, flow engines and baud generator supply the event inputs
`default_nettype none

package uart_irq_pkg;

    // register addresses on the three-bit register bus
    localparam logic [2:0] ADDR_DATA = 3'h0;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_ISR = 3'h2;
    localparam logic [2:0] ADDR_LSR = 3'h5;
    localparam logic [2:0] ADDR_MSR = 3'h6;

    // interrupt enable field positions
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_LS = 2;
    localparam int IER_MS = 3;
    localparam int IER_SLEEP = 4;
    localparam int IER_XOFF = 5;
    localparam int IER_RTS = 6;
    localparam int IER_CTS = 7;
    localparam logic [7:0] IER_RESET = 8'h00;
    localparam logic [7:0] IER_BASE_MASK = 8'h0F;

    // status codes for bits 5:0, priority 1 first
    localparam logic [5:0] CODE_LS = 6'h06;
    localparam logic [5:0] CODE_TO = 6'h0C;
    localparam logic [5:0] CODE_RX = 6'h04;
    localparam logic [5:0] CODE_TX = 6'h02;
    localparam logic [5:0] CODE_MS = 6'h00;
    localparam logic [5:0] CODE_XCH = 6'h10;
    localparam logic [5:0] CODE_FLOW = 6'h20;
    localparam logic [5:0] CODE_NONE = 6'h01;
    localparam logic [7:0] ISR_RESET = 8'h01;
    localparam logic [7:0] LSR_RESET = 8'h60;

    // receive time-out: characters plus bits
    localparam int TIMEOUT_CHARS = 4;
    localparam int TIMEOUT_BITS = 12;

    // events and levels from the surrounding uart, all on this clock
    typedef struct packed {
        logic fifo_en;
        logic rx_at_trigger;
        logic rhr_full;
        logic rx_empty;
        logic char_rx;
        logic overrun;
        logic [2:0] head_err;
        logic enq_err;
        logic fifo_err;
        logic thr_empty;
        logic tx_below_trig;
        logic tx_all_empty;
        logic msr_any;
        logic xon;
        logic xoff;
        logic special;
        logic rts_out;
        logic wake;
        logic bit_tick;
    } uart_evt_s;

    // configuration bits held in other registers
    typedef struct packed {
        logic enh;
        logic auto_rts;
        logic auto_cts;
        logic early_err;
        logic wake_en;
        logic dlab;
        logic [3:0] char_bits;
    } uart_cfg_s;

endpackage

`default_nettype wire

/* uart_host_model.sv */
// host model: drives the parallel register bus of the interrupt block
// assumes the block synchronises the strobes itself, so timing is in whole clocks
`default_nettype none

module uart_host_model (
    input wire logic clock,
    output logic bus_cs_n,
    output logic bus_rd_n,
    output logic bus_wr_n,
    output logic [2:0] bus_addr,
    output logic [7:0] bus_data_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial
    begin
        bus_cs_n = 1'b1;
        bus_rd_n = 1'b1;
        bus_wr_n = 1'b1;
        bus_addr = 3'h0;
        bus_data_in = 8'h00;
    end

    // strobe low six clocks, high five: the pins pass a 3-flop sync
    task automatic access(input logic wr, input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_data_in <= d;
        bus_cs_n <= 1'b0;
        bus_rd_n <= wr;
        bus_wr_n <= !wr;
        repeat (6) @(posedge clock);
        bus_cs_n <= 1'b1;
        bus_rd_n <= 1'b1;
        bus_wr_n <= 1'b1;
        // released lines show the inverse, so stale values are never trusted
        bus_addr <= ~a;
        bus_data_in <= ~d;
        repeat (5) @(posedge clock);
    endtask
endmodule

`default_nettype wire

/* uart_interrupt_enable_status_test.sv */
// self-checking bench for the uart interrupt enable and status block
// assumes uart_host_model drives the register bus; events come from here
`default_nettype none

module uart_interrupt_enable_status_test;
    import uart_irq_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {logic [7:0] d; logic [7:0] m;} exp_s;

    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic cts_n = 1'b0;
    logic oe_q = 1'b0;
    logic bus_cs_n, bus_rd_n, bus_wr_n, bus_data_oe, irq, sleep_en;
    logic [2:0] bus_addr;
    logic [7:0] bus_data_in, bus_data_out, line_status;
    uart_evt_s evt;
    uart_evt_s pm;
    uart_cfg_s cfg;
    exp_s exp_q[$];
    exp_s x;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cb;

    // 100 MHz
    always #5 clock = ~clock;

    uart_host_model host (.clock(clock), .bus_cs_n(bus_cs_n), .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n),
        .bus_addr(bus_addr), .bus_data_in(bus_data_in));

    uart_interrupt_enable_status #(.TMR_W(8)) DUT (.clock(clock), .arst_n(arst_n), .bus_cs_n(bus_cs_n),
        .bus_rd_n(bus_rd_n), .bus_wr_n(bus_wr_n), .bus_addr(bus_addr), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .cts_n(cts_n), .evt(evt), .cfg(cfg),
        .irq(irq), .sleep_en(sleep_en), .line_status(line_status));

    task automatic cmp_byte(input logic [7:0] got, input logic [7:0] e, input logic [7:0] m);
        samples_checked++;
        if (((got ^ e) & m) !== 8'h00)
        begin
            n_mismatch++;
            $display("[ERR] %0t byte %h expected %h mask %h", $time, got, e, m);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic e);
        samples_checked++;
        if (got !== e)
        begin
            n_mismatch++;
            $display("[ERR] %0t bit %b expected %b", $time, got, e);
        end
    endtask

    // a read notes its expectation; the monitor below does the compare
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        exp_q.push_back({e, m});
        host.access(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        host.access(1'b1, a, d);
    endtask

    // one-cycle pulse on the event fields set in m
    task automatic pulse(input uart_evt_s m);
        @(posedge clock);
        evt <= uart_evt_s'(evt | m);
        @(posedge clock);
        evt <= uart_evt_s'(evt & ~m);
    endtask

    task automatic chk_irq(input logic e, input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
        cmp_bit(irq, e);
        @(posedge clock); // stimulus resumes on the rising edge
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // read data is settled by the falling edge after output enable rises
    always @(negedge clock)
    begin
        if (bus_data_oe === 1'b1 && oe_q !== 1'b1)
        begin
            if (exp_q.size() == 0)
                cmp_bit(1'b1, 1'b0);
            else
            begin
                x = exp_q.pop_front();
                cmp_byte(bus_data_out, x.d, x.m);
            end
        end
        oe_q = bus_data_oe;
    end

    // whole run is under seven hundred clocks; generous margin
    initial
    begin
        #200us;
        n_mismatch++;
        end_sim();
    end

    // main sequence
    initial
    begin
        void'($urandom(32'h43b7_a6c9));
        evt = '0;
        cfg = '0;
        evt.thr_empty = 1'b1;
        evt.tx_all_empty = 1'b1;
        evt.rx_empty = 1'b1;
        cfg.char_bits = 4'h8;
        repeat (4) @(posedge clock);
        arst_n <= 1'b1;
        rd(ADDR_IER, IER_RESET, 8'hFF);
        rd(ADDR_ISR, ISR_RESET, 8'hFF);
        rd(3'h3, 8'h00, 8'hFF);
        cmp_byte(line_status, LSR_RESET, 8'hFF);
        // upper enables need enhanced mode; random pattern, no events pending
        cb = $urandom;
        cfg.enh <= 1'b1;
        wr(ADDR_IER, {cb[7:4], 4'h0});
        rd(ADDR_IER, {cb[7:4], 4'h0}, 8'hFF);
        cmp_bit(sleep_en, cb[4]);
        cfg.enh <= 1'b0;
        chk_irq(1'b0, 3);
        cmp_bit(sleep_en, 1'b0);
        // non-fifo mode: an already empty holding register interrupts at once
        wr(ADDR_IER, 8'h02);
        chk_irq(1'b1, 3);
        rd(ADDR_ISR, {2'b00, CODE_TX}, 8'hFF);
        rd(ADDR_ISR, ISR_RESET, 8'hFF);
        chk_irq(1'b0, 3);
        // re-enable raises it again; a holding write clears it
        wr(ADDR_IER, 8'h00);
        wr(ADDR_IER, 8'h02);
        chk_irq(1'b1, 3);
        cb = $urandom;
        wr(ADDR_DATA, cb[7:0]);
        chk_irq(1'b0, 3);
        // four sources at once, served in priority order
        evt.fifo_en <= 1'b1;
        evt.rx_empty <= 1'b0;
        evt.rx_at_trigger <= 1'b1;
        evt.thr_empty <= 1'b0;
        evt.msr_any <= 1'b1;
        wr(ADDR_IER, IER_BASE_MASK);
        evt.tx_below_trig <= 1'b1; // tx condition rises while enabled
        pm = '0;
        pm.overrun = 1'b1;
        pulse(pm);
        rd(ADDR_ISR, {2'b11, CODE_LS}, 8'hFF);
        rd(ADDR_LSR, 8'h02, 8'h02);
        rd(ADDR_ISR, {2'b11, CODE_RX}, 8'hFF);
        evt.rx_at_trigger <= 1'b0;
        rd(ADDR_ISR, {2'b11, CODE_TX}, 8'hFF);
        rd(ADDR_ISR, {2'b11, CODE_MS}, 8'hFF);
        evt.msr_any <= 1'b0;
        rd(ADDR_ISR, 8'hC1, 8'hFF);
        chk_irq(1'b0, 3);
        evt.thr_empty <= 1'b1;
        evt.tx_below_trig <= 1'b0;
        // time-out at exactly four characters plus twelve bits
        cb = 5 + $urandom % 4;
        cfg.char_bits <= cb[3:0];
        wr(ADDR_IER, 8'h01);
        pm = '0;
        pm.bit_tick = 1'b1;
        repeat (TIMEOUT_CHARS * cb + TIMEOUT_BITS - 1) pulse(pm);
        chk_irq(1'b0, 3);
        pulse(pm);
        chk_irq(1'b1, 3);
        rd(ADDR_ISR, {2'b11, CODE_TO}, 8'hFF);
        rd(ADDR_DATA, 8'h00, 8'h00);
        chk_irq(1'b0, 3);
        evt.rx_empty <= 1'b1;
        // head error, then early error on enqueue
        for (int k = 0; k < 2; k++)
        begin
            cfg.early_err <= k[0];
            wr(ADDR_IER, 8'h04);
            evt.head_err <= k[0] ? 3'b000 : 3'b100;
            pm = '0;
            pm.enq_err = k[0];
            pulse(pm);
            chk_irq(1'b1, 3);
            rd(ADDR_ISR, {2'b11, CODE_LS}, 8'hFF);
            evt.head_err <= 3'b000;
            rd(ADDR_LSR, 8'h00, 8'h00);
            rd(ADDR_ISR, 8'hC1, 8'hFF);
        end
        // cts then rts rising under automatic flow control
        cfg.enh <= 1'b1;
        cfg.auto_cts <= 1'b1;
        cfg.auto_rts <= 1'b1;
        wr(ADDR_IER, 8'hE0);
        for (int k = 0; k < 2; k++)
        begin
            if (k == 0)
                cts_n <= 1'b1;
            else
                evt.rts_out <= 1'b1;
            chk_irq(1'b1, 6);
            rd(ADDR_ISR, {2'b11, CODE_FLOW}, 8'hFF);
            rd(ADDR_MSR, 8'h00, 8'h00);
            rd(ADDR_ISR, 8'hC1, 8'hFF);
        end
        // character match, cleared by status read or next character
        pm = '0;
        pm.xoff = 1'b1;
        pulse(pm);
        rd(ADDR_ISR, {2'b11, CODE_XCH}, 8'hFF);
        rd(ADDR_ISR, 8'hC1, 8'hFF);
        pm = '0;
        pm.special = 1'b1;
        pulse(pm);
        chk_irq(1'b1, 3);
        pm = '0;
        pm.char_rx = 1'b1;
        pulse(pm);
        chk_irq(1'b0, 3);
        // wake-up shows the no-interrupt code
        cfg.wake_en <= 1'b1;
        pm = '0;
        pm.wake = 1'b1;
        pulse(pm);
        chk_irq(1'b1, 3);
        rd(ADDR_ISR, 8'hC1, 8'hFF);
        chk_irq(1'b0, 3);
        // polled use: enables off, the host watches line status alone
        wr(ADDR_IER, 8'h00);
        evt.fifo_err <= 1'b1;
        evt.tx_all_empty <= 1'b0;
        evt.rx_empty <= 1'b0;
        pm = '0;
        pm.char_rx = 1'b1;
        pulse(pm);
        chk_irq(1'b0, 3);
        cmp_byte(line_status, 8'hA1, 8'hFF);
        evt.rx_empty <= 1'b1;
        chk_irq(1'b0, 3);
        cmp_byte(line_status, 8'hA0, 8'hFF);
        end_sim();
    end
endmodule

`default_nettype wire
